// ---- hdl/bspie_pkg.sv ----
// Shared constants for the bit-serial prioritized interrupt encoder and its host end
package bspie_pkg;

  // ==========================================================================
  // Port geometry
  localparam int unsigned IRQ_COUNT = 15;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned SEL_W = 5;
  localparam logic [4:0] SEL_CONTROL = 5'h00;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic [14:0] MASK_RESET = 15'h0000;
  localparam logic CONTROL_RESET = 1'b0;
  localparam logic [3:0] IRQ_LAST_CODE = 4'hF;

  // ==========================================================================
  // Link timing, host side
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_SETUP_NS = 200;
  localparam int unsigned T_STROBE_NS = 100;
  localparam int unsigned T_HOLD_NS = 80;
  localparam int unsigned T_READ_NS = 330;
  localparam int unsigned SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 7;

  // ==========================================================================
  // Host register map
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;
  localparam int unsigned CMD_SEL_LSB = 0;
  localparam int unsigned CMD_WRITE_BIT = 5;
  localparam int unsigned CMD_DATA_BIT = 6;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_RDBIT_BIT = 1;
  localparam int unsigned ST_CODE_LSB = 2;
  localparam int unsigned ST_REQ_BIT = 6;
  localparam int unsigned EV_DONE_BIT = 0;
  localparam int unsigned EV_REQ_BIT = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [1:0] EV_RESET = 2'h0;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_READ
  } bspie_hstate_t;

endpackage

// ---- hdl/bspie_if.sv ----
// Serial bit port between the encoder and its host
interface bspie_if;
  logic high_select_line;
  logic [3:0] bit_select_lines;
  logic cs_n;
  logic serial_read_line;
  logic serial_write_line;
  logic write_strobe;
  logic [3:0] priority_code_out;
  logic irq_request_n;

  modport dev (
    input high_select_line, bit_select_lines, cs_n, serial_write_line, write_strobe,
    output serial_read_line, priority_code_out, irq_request_n
  );

  modport host (
    output high_select_line, bit_select_lines, cs_n, serial_write_line, write_strobe,
    input serial_read_line, priority_code_out, irq_request_n
  );
endinterface

// ---- hdl/bspie_device.sv ----
// Encoder end: mask bits, priority encoder, serial bit port slave and pin synchroniser
// Functional notes
// R01 - Low four select lines pick the bit
// R02 - High select is top bit, else low
// R03 - Read line high while not selected
// R04 - Selected read returns the addressed bit
// R05 - Strobe stores write line into bit
// R06 - Host strobes only with valid data
// R07 - Reset clears masks, halts clocked logic
// R08 - Transfers only with chip select low
// R09 - Code outputs give highest enabled input
// R10 - Request low when enabled input encoded
// R11 - Code and request leave flip-flops
// R12 - Inputs active low, gated by masks
// R13 - Input one highest, fifteen lowest
// R14 - Code equals the input number
// R15 - Sample, then present next clock edge
// R16 - Idle: request high, code holds
// R17 - Interrupt mode: one enables, zero disables
// R18 - Reset forces code zero, request high
//
// Design decisions made here: strobed register access and the register addresses.
module bspie_device (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Interrupt sources, bit n-1 is input n
  input wire logic [14:0] IRQ_INPUTS_N,
  // Serial bit port
  bspie_if.dev LINK
);

  // ==========================================================================
  // Pin synchronisers
  // Every pin crosses two flops before any decode reads it; the strobe gets a
  // third so that its rising edge is found on settled levels only
  logic [14:0] irq_s_q;
  logic [4:0] sel_s_q;
  logic cs_s_q;
  logic wd_s_q;
  logic stb_s_q;
  logic stb_p_q;

  bspie_sync #(.WIDTH(15), .IDLE(15'h7FFF)) irq_sync_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin(IRQ_INPUTS_N),
    .settled(irq_s_q)
  );

  bspie_sync #(.WIDTH(5), .IDLE(5'h00)) sel_sync_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin({LINK.high_select_line, LINK.bit_select_lines}),
    .settled(sel_s_q)
  );

  bspie_sync #(.WIDTH(1), .IDLE(1'b1)) cs_sync_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin(LINK.cs_n),
    .settled(cs_s_q)
  );

  bspie_sync #(.WIDTH(1), .IDLE(1'b0)) wd_sync_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin(LINK.serial_write_line),
    .settled(wd_s_q)
  );

  bspie_sync #(.WIDTH(1), .IDLE(1'b0)) stb_sync_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .pin(LINK.write_strobe),
    .settled(stb_s_q)
  );

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      stb_p_q <= 1'b0;
    end else begin
      stb_p_q <= stb_s_q;
    end
  end

  // ==========================================================================
  // Bit decode
  logic selected;
  logic strobe_rise;
  logic [3:0] bit_idx;
  // A companion part owns the upper half; this one answers only with it low
  assign selected = !cs_s_q && !sel_s_q[4]; // R02 R08
  assign bit_idx = sel_s_q[3:0]; // R01
  // Data meets its setup well before the strobe, so both arrive settled
  assign strobe_rise = stb_s_q && !stb_p_q; // R06

  // ==========================================================================
  // Control bit and masks
  logic control_q;
  logic [14:0] mask_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      control_q <= bspie_pkg::CONTROL_RESET;
    end else if (selected && strobe_rise && {1'b0, bit_idx} == bspie_pkg::SEL_CONTROL) begin
      control_q <= wd_s_q; // R05
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mask_q <= bspie_pkg::MASK_RESET; // R07
    end else if (selected && strobe_rise && bit_idx != 4'h0 && !control_q) begin
      mask_q[bit_idx - 4'h1] <= wd_s_q; // R05 R17
    end
  end

  // ==========================================================================
  // Priority encoder
  logic [14:0] enabled;
  logic [3:0] enc;
  assign enabled = ~irq_s_q & mask_q; // R12

  always_comb begin
    enc = 4'h0;
    for (int i = bspie_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        enc = 4'(i + 1); // R13 R14
      end
    end
  end

  logic [3:0] code_q;
  logic req_n_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      req_n_q <= 1'b1; // R18
    end else begin
      req_n_q <= ~|enabled; // R10 R15 R16
    end
  end

  // The code keeps its last value once the request drops
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      code_q <= bspie_pkg::CODE_RESET; // R18
    end else if (|enabled) begin
      code_q <= enc; // R09 R11
    end
  end

  // ==========================================================================
  // Read side
  logic rd_bit;
  logic rd_q;

  always_comb begin
    if (bit_idx == 4'h0) begin
      rd_bit = control_q;
    end else if (bit_idx == bspie_pkg::IRQ_LAST_CODE && control_q) begin
      rd_bit = req_n_q;
    end else begin
      // Raw pin level, whatever the mask says
      rd_bit = irq_s_q[bit_idx - 4'h1];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rd_q <= 1'b1;
    end else if (selected) begin
      rd_q <= rd_bit; // R04
    end else begin
      rd_q <= 1'b1; // R03
    end
  end

  assign LINK.serial_read_line = rd_q;
  assign LINK.priority_code_out = code_q; // R09
  assign LINK.irq_request_n = req_n_q;

endmodule // bspie_device

// ==========================================================================
// Two-flop synchroniser for pins from outside the clock domain
module bspie_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Pin level and its settled copy
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] settled
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] settled_q;

  // Reset loads the idle level so that no false edge follows release
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      meta_q <= IDLE;
      settled_q <= IDLE;
    end else begin
      meta_q <= pin;
      settled_q <= meta_q;
    end
  end

  // Only the second flop leaves the module
  assign settled = settled_q;

endmodule // bspie_sync

// ---- hdl/bspie_host.sv ----
// Host end: drives the serial bit port from a small register file
module bspie_host (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Interrupt
  output logic IRQ,
  // Serial bit port
  bspie_if.host LINK
);

  // ==========================================================================
  // Device output synchronisers
  logic rl_m_q, rl_s_q;
  logic [3:0] code_m_q, code_s_q;
  logic req_m_q, req_s_q, req_p_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rl_m_q <= 1'b1;
      rl_s_q <= 1'b1;
      code_m_q <= 4'h0;
      code_s_q <= 4'h0;
      req_m_q <= 1'b1;
      req_s_q <= 1'b1;
      req_p_q <= 1'b1;
    end else begin
      rl_m_q <= LINK.serial_read_line;
      rl_s_q <= rl_m_q;
      code_m_q <= LINK.priority_code_out;
      code_s_q <= code_m_q;
      req_m_q <= LINK.irq_request_n;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
    end
  end

  // ==========================================================================
  // Transfer sequencer
  bspie_pkg::bspie_hstate_t state_q;
  logic [6:0] cnt_q;
  logic [4:0] sel_q;
  logic is_wr_q, wd_q, cs_n_q, stb_q, rdbit_q, done;
  logic cmd_go;

  assign cmd_go = WR && ADDR == bspie_pkg::REG_CMD && state_q == bspie_pkg::H_IDLE;
  assign done = (state_q == bspie_pkg::H_HOLD || state_q == bspie_pkg::H_READ) && cnt_q == 7'h00;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q <= bspie_pkg::H_IDLE;
      cnt_q <= 7'h00;
      sel_q <= 5'h00;
      is_wr_q <= 1'b0;
      wd_q <= 1'b0;
      cs_n_q <= 1'b1;
      stb_q <= 1'b0;
      rdbit_q <= 1'b1;
    end else begin
      unique case (state_q)
        bspie_pkg::H_IDLE: begin
          if (cmd_go) begin
            sel_q <= WDATA[bspie_pkg::CMD_SEL_LSB +: 5]; // R01 R02
            is_wr_q <= WDATA[bspie_pkg::CMD_WRITE_BIT];
            wd_q <= WDATA[bspie_pkg::CMD_DATA_BIT];
            cs_n_q <= 1'b0; // R08
            cnt_q <= WDATA[bspie_pkg::CMD_WRITE_BIT] ? 7'(bspie_pkg::SETUP_CYC - 1)
                                                     : 7'(bspie_pkg::READ_CYC - 1);
            state_q <= WDATA[bspie_pkg::CMD_WRITE_BIT] ? bspie_pkg::H_SETUP
                                                       : bspie_pkg::H_READ;
          end
        end
        bspie_pkg::H_SETUP: begin
          if (cnt_q == 7'h00) begin
            stb_q <= 1'b1; // R06
            cnt_q <= 7'(bspie_pkg::STROBE_CYC - 1);
            state_q <= bspie_pkg::H_STROBE;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        bspie_pkg::H_STROBE: begin
          if (cnt_q == 7'h00) begin
            stb_q <= 1'b0;
            cnt_q <= 7'(bspie_pkg::HOLD_CYC - 1);
            state_q <= bspie_pkg::H_HOLD;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        bspie_pkg::H_HOLD, bspie_pkg::H_READ: begin
          if (cnt_q == 7'h00) begin
            if (state_q == bspie_pkg::H_READ) begin
              rdbit_q <= rl_s_q;
            end
            cs_n_q <= 1'b1;
            state_q <= bspie_pkg::H_IDLE;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Events, mask and interrupt
  logic [1:0] ev_q, mask_q, ev_set;
  logic irq_q;
  assign ev_set = {req_p_q && !req_s_q, done};

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ev_q <= bspie_pkg::EV_RESET;
      mask_q <= bspie_pkg::EV_RESET;
      irq_q <= 1'b0;
    end else begin
      // A new event wins over a clear landing in the same cycle
      if (WR && ADDR == bspie_pkg::REG_IRQ_STAT) begin
        ev_q <= (ev_q & ~WDATA[1:0]) | ev_set;
      end else begin
        ev_q <= ev_q | ev_set;
      end
      if (WR && ADDR == bspie_pkg::REG_IRQ_MASK) begin
        mask_q <= WDATA[1:0];
      end
      irq_q <= |(ev_q & mask_q);
    end
  end

  // ==========================================================================
  // Register reads
  logic [31:0] rdata_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        bspie_pkg::REG_CMD: rdata_q <= {25'h000_0000, wd_q, is_wr_q, sel_q};
        bspie_pkg::REG_STATUS: begin
          rdata_q <= {25'h000_0000, !req_s_q, code_s_q, rdbit_q,
                      state_q != bspie_pkg::H_IDLE};
        end
        bspie_pkg::REG_IRQ_STAT: rdata_q <= {30'h0000_0000, ev_q};
        bspie_pkg::REG_IRQ_MASK: rdata_q <= {30'h0000_0000, mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign LINK.high_select_line = sel_q[4];
  assign LINK.bit_select_lines = sel_q[3:0];
  assign LINK.cs_n = cs_n_q;
  assign LINK.serial_write_line = wd_q;
  assign LINK.write_strobe = stb_q;

endmodule // bspie_host

// ---- sim/bspie_assertions.sv ----
// Concurrent checks on the serial bit port between host end and encoder end
module bspie_assertions (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Host to encoder
  input wire logic high_select_line,
  input wire logic [3:0] bit_select_lines,
  input wire logic cs_n,
  input wire logic serial_write_line,
  input wire logic write_strobe,
  // Encoder to host
  input wire logic serial_read_line,
  input wire logic [3:0] priority_code_out,
  input wire logic irq_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Port checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // Reset itself is the antecedent here, so this one is never disabled
  AST_RESET_OUT: assert property (disable iff (1'b0) !RST_N ##1 !RST_N |->
    irq_request_n && serial_read_line && priority_code_out == 4'h0)
    else $error("outputs not cleared during reset");
  AST_READ_IDLE: assert property (cs_n [*4] |-> serial_read_line)
    else $error("read line low while unselected");
  AST_REQ_CODE: assert property (!irq_request_n |-> priority_code_out != 4'h0)
    else $error("request active with empty code");
  AST_CODE_HOLD: assert property (irq_request_n && $past(irq_request_n)
    |-> $stable(priority_code_out))
    else $error("code moved while idle");
  AST_CODE_CAUSE: assert property ($changed(priority_code_out) |-> !irq_request_n)
    else $error("code changed without request");
  AST_STROBE_SETUP: assert property ($rose(write_strobe) |-> !$past(cs_n, 40))
    else $error("strobe without select setup");
  AST_STROBE_WIDTH: assert property ($rose(write_strobe) |-> write_strobe [*8])
    else $error("strobe too short");
  AST_STROBE_DATA: assert property (write_strobe && $past(write_strobe) |->
    !cs_n && $stable(serial_write_line) && $stable(bit_select_lines)
    && $stable(high_select_line))
    else $error("port moved during strobe");
  AST_CS_BOUND: assert property ($fell(cs_n) |-> ##[1:120] cs_n)
    else $error("chip select held too long");
endmodule // bspie_assertions

// ---- sim/testbench.sv ----
// Self-checking bench: host end and encoder end joined back to back
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [14:0] irq_inputs_n = 15'h7FFF;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [31:0] v;
  int failures = 0;
  int n_tests = 0;

  bspie_if lnk();
  bspie_device bspie_device_i (.CLOCK(CLOCK), .RST_N(RST_N), .IRQ_INPUTS_N(irq_inputs_n),
    .LINK(lnk));
  bspie_host bspie_host_i (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ(irq), .LINK(lnk));
  bspie_assertions bspie_assertions_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .high_select_line(lnk.high_select_line), .bit_select_lines(lnk.bit_select_lines),
    .cs_n(lnk.cs_n), .serial_write_line(lnk.serial_write_line),
    .write_strobe(lnk.write_strobe), .serial_read_line(lnk.serial_read_line),
    .priority_code_out(lnk.priority_code_out), .irq_request_n(lnk.irq_request_n));

  always #2 CLOCK = ~CLOCK;

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLOCK);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge CLOCK);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLOCK);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Waits for the link to go idle; leaves the final status word in v
  task automatic wait_idle();
    v = 32'h1;
    for (int k = 0; k < 300 && v[0]; k++) rreg(bspie_pkg::REG_STATUS);
    check(v[0], 1'b0);
  endtask
  // One link transfer; leaves the final status word in v
  task automatic xfer(input logic [4:0] sel, input logic w, input logic d);
    wreg(bspie_pkg::REG_CMD, {25'h0, d, w, sel});
    wait_idle();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_reset();
    rreg(bspie_pkg::REG_STATUS);
    check(v & 32'h0000_007D, 32'h0);
    check({irq, lnk.serial_read_line, lnk.irq_request_n}, 3'h3);
    xfer(5'h00, 1'b0, 1'b0);
    check(v[1], 1'b0);
  endtask
  task automatic s_prio();
    for (int n = 1; n <= 15; n++) xfer(n[4:0], 1'b1, 1'b1);
    // Lower priorities stay asserted, so each step must take over the code
    for (int n = 15; n >= 1; n--) begin
      @(posedge CLOCK);
      irq_inputs_n[n-1] <= 1'b0;
      repeat (2) @(posedge CLOCK);
      #1 check(lnk.priority_code_out, (n == 15) ? 4'h0 : n[3:0] + 4'h1);
      @(posedge CLOCK);
      #1 check(lnk.priority_code_out, n[3:0]);
      check(lnk.irq_request_n, 1'b0);
    end
    @(posedge CLOCK);
    irq_inputs_n <= 15'h7FFF;
    repeat (4) @(posedge CLOCK);
    #1 check({lnk.irq_request_n, lnk.priority_code_out}, 5'h11);
  endtask
  task automatic s_mask();
    xfer(5'h03, 1'b1, 1'b0);
    @(posedge CLOCK);
    irq_inputs_n[2] <= 1'b0;
    repeat (5) @(posedge CLOCK);
    #1 check(lnk.irq_request_n, 1'b1);
    xfer(5'h03, 1'b0, 1'b0);
    check(v[1], 1'b0);
    xfer(5'h04, 1'b0, 1'b0);
    check(v[1], 1'b1);
    xfer(5'h13, 1'b1, 1'b1);
    #1 check(lnk.irq_request_n, 1'b1);
    xfer(5'h13, 1'b0, 1'b0);
    check(v[1], 1'b1);
    @(posedge CLOCK);
    irq_inputs_n <= 15'h7FFF;
  endtask
  task automatic s_irq();
    wreg(bspie_pkg::REG_IRQ_STAT, 32'h0000_0003);
    wreg(bspie_pkg::REG_IRQ_MASK, 32'h0000_0002);
    irq_inputs_n[6] <= 1'b0;
    repeat (10) @(posedge CLOCK);
    #1 check(irq, 1'b1);
    check(lnk.priority_code_out, 4'h7);
    rreg(bspie_pkg::REG_IRQ_STAT);
    check(v, 32'h2);
    wreg(bspie_pkg::REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge CLOCK);
    #1 check(irq, 1'b0);
    wreg(bspie_pkg::REG_IRQ_STAT, 32'h0000_0002);
    wreg(bspie_pkg::REG_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge CLOCK);
    #1 check(irq, 1'b0);
    rreg(bspie_pkg::REG_IRQ_MASK);
    check(v, 32'h2);
    rreg(4'h2);
    check(v, 32'h0);
    @(posedge CLOCK);
    irq_inputs_n <= 15'h7FFF;
  endtask
  // Control bit set: mask writes are dropped and bit 15 reads the request
  task automatic s_control();
    wreg(bspie_pkg::REG_CMD, 32'h0000_0000);
    wreg(bspie_pkg::REG_CMD, 32'h0000_0060);
    wait_idle();
    check(v[1], 1'b0);
    rreg(bspie_pkg::REG_CMD);
    check(v, 32'h0);
    rreg(bspie_pkg::REG_IRQ_STAT);
    check(v, 32'h1);
    xfer(5'h00, 1'b1, 1'b1);
    xfer(5'h00, 1'b0, 1'b0);
    check(v[1], 1'b1);
    xfer(5'h05, 1'b1, 1'b0);
    @(posedge CLOCK);
    irq_inputs_n[4] <= 1'b0;
    repeat (4) @(posedge CLOCK);
    #1 check({lnk.irq_request_n, lnk.priority_code_out}, 5'h05);
    xfer(5'h0F, 1'b0, 1'b0);
    check(v[1], 1'b0);
    @(posedge CLOCK);
    irq_inputs_n <= 15'h7FFF;
    xfer(5'h00, 1'b1, 1'b0);
  endtask
  // Masks were enabled before this reset, so a request now means they survived
  task automatic s_midreset();
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    RST_N <= 1'b1;
    irq_inputs_n[0] <= 1'b0;
    repeat (6) @(posedge CLOCK);
    #1 check(lnk.irq_request_n, 1'b1);
    check(lnk.priority_code_out, 4'h0);
  endtask

  initial begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    s_reset();
    s_prio();
    s_mask();
    s_irq();
    s_control();
    s_midreset();
    finish_test();
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // testbench
